// file: bench/pin_source.sv
// Purpose: Model of the outside sources that drive the eight pins.
// Assumes: Sources are synchronous to sys_clk and change after its rising edge.
// Notes: Each level is held at least four cycles so the block always sees the edge.
`default_nettype none
module pin_source (
  // Clock
  input wire logic sys_clk,
  // Pins
  output var logic [7:0] ext_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    ext_pin = 8'h00;
  end
  task automatic put(input logic [7:0] lvl);
    @(posedge sys_clk);
    ext_pin <= lvl;
    repeat (3) @(posedge sys_clk);
  endtask : put
endmodule : pin_source
`default_nettype wire

// file: bench/tb_top.sv
// Purpose: Self-checking bench for the external interrupt block.
// Assumes: Register offsets and reset values come from the shared package.
// Notes: Pin activity is made by the pin_source model.
`default_nettype none
module tb_top
  import ext_irq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic [ADDR_W-1:0] reg_addr = 4'h0;
  logic [DATA_W-1:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [DATA_W-1:0] reg_rdata;
  logic [7:0] ext_pin;
  logic irq_req;
  logic evt_irq;
  int num_errors = 0;
  int checked = 0;
  always #50 sys_clk = ~sys_clk;
  pin_source pins_u (.sys_clk(sys_clk), .ext_pin(ext_pin));
  port_ext_irq_edge_detect dut_u (.sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ext_pin(ext_pin), .irq_req(irq_req), .evt_irq(evt_irq));
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string what);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk(what, exp, reg_rdata);
  endtask : rd
  task automatic t_regs();
    rd(OFS_ENABLE, RST_ENABLE, "enable reset");
    rd(OFS_FLAGS, RST_FLAGS, "flags reset");
    rd(OFS_POLARITY, RST_POLARITY, "polarity reset");
    rd(OFS_DIRECTION, RST_DIRECTION, "direction reset");
    rd(4'hF, UNMAPPED_READ, "unmapped");
    wr(OFS_ENABLE, 8'hA5);
    rd(OFS_ENABLE, 8'hA5, "enable rw");
    $display("test regs done");
  endtask : t_regs
  task automatic t_edges();
    wr(OFS_ENABLE, 8'h00);
    wr(OFS_POLARITY, 8'hAA);
    rd(OFS_POLARITY, 8'hAA, "polarity rw");
    pins_u.put(8'hFF);
    rd(OFS_FLAGS, 8'h55, "rising flags");
    pins_u.put(8'h00);
    rd(OFS_FLAGS, 8'hFF, "falling flags");
    pins_u.put(8'hFF);
    rd(OFS_FLAGS, 8'hFF, "sticky flags");
    chk("irq masked", 8'h00, {7'h00, irq_req});
    rd(OFS_EVT_STATUS, 8'hFF, "evt status");
    wr(OFS_EVT_ENABLE, 8'h01);
    chk("evt raised", 8'h01, {7'h00, evt_irq});
    wr(OFS_EVT_ENABLE, 8'h00);
    chk("evt masked", 8'h00, {7'h00, evt_irq});
    wr(OFS_EVT_CLEAR, 8'hFF);
    wr(OFS_EVT_ENABLE, 8'h01);
    chk("evt cleared", 8'h00, {7'h00, evt_irq});
    wr(OFS_FLAGS, 8'h00);
    rd(OFS_FLAGS, 8'h00, "flags cleared");
    $display("test edges done");
  endtask : t_edges
  task automatic t_soft_irq();
    wr(OFS_ENABLE, 8'h10);
    wr(OFS_FLAGS, 8'h08);
    chk("irq off channel", 8'h00, {7'h00, irq_req});
    wr(OFS_FLAGS, 8'h18);
    chk("irq soft set", 8'h01, {7'h00, irq_req});
    wr(OFS_FLAGS, 8'h00);
    chk("irq dropped", 8'h00, {7'h00, irq_req});
    $display("test soft irq done");
  endtask : t_soft_irq
  task automatic t_direction();
    wr(OFS_POLARITY, 8'h00);
    wr(OFS_DIRECTION, 8'hFF);
    pins_u.put(8'h00);
    pins_u.put(8'hFF);
    rd(OFS_FLAGS, 8'h00, "output pins");
    $display("test direction done");
  endtask : t_direction
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : print_verdict
  initial begin
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    t_regs();
    t_edges();
    t_soft_irq();
    t_direction();
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire

// file: rtl/ext_irq_pkg.sv
// Purpose: Shared constants for the eight-channel external interrupt block.
// Assumes: Plain register port with 8-bit data in the low bits of each word.
// Notes: Offsets are word indices on the plain register port.
`default_nettype none
package ext_irq_pkg;
  localparam int NUM_CHAN = 8;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] OFS_ENABLE = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_FLAGS = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_POLARITY = 4'h2;
  localparam logic [ADDR_W-1:0] OFS_DIRECTION = 4'h3;
  localparam logic [ADDR_W-1:0] OFS_EVT_STATUS = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_EVT_CLEAR = 4'h5;
  localparam logic [ADDR_W-1:0] OFS_EVT_ENABLE = 4'h6;
  localparam logic [DATA_W-1:0] RST_ENABLE = 8'h00;
  localparam logic [DATA_W-1:0] RST_FLAGS = 8'h00;
  localparam logic [DATA_W-1:0] RST_POLARITY = 8'h00;
  localparam logic [DATA_W-1:0] RST_DIRECTION = 8'h00;
  localparam logic [DATA_W-1:0] RST_EVT = 8'h00;
  localparam logic [DATA_W-1:0] UNMAPPED_READ = 8'h00;
endpackage : ext_irq_pkg
`default_nettype wire

// file: rtl/port_ext_irq_edge_detect.sv
// Purpose: Edge-detecting external interrupt logic for eight port pins.
// Assumes: Pins are synchronous to sys_clk; one sys_clk domain; sync reset.
// Notes: Edge events also set sticky status bits for a second, maskable line.
// Notes on behaviour
// - Each channel has one enable bit, 0 disables and 1 enables its interrupt.
// - A pin edge of the selected polarity sets that channel's flag when its direction bit is 0 (input).
// - A flag stays set until software writes it to zero.
// - A flag set by software raises a request just like an edge when enabled.
// - Polarity bit 0 selects rising edges and 1 selects falling edges.
// - Each polarity bit affects only its own channel.
`default_nettype none
module port_ext_irq_edge_detect
  import ext_irq_pkg::*;
#(
  parameter int CHANNELS = NUM_CHAN
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  // Port pins
  input wire logic [CHANNELS-1:0] ext_pin,
  // Interrupt lines
  output logic irq_req,
  output logic evt_irq
);

  logic [CHANNELS-1:0] ext_irq_enable_reg_q;
  logic [CHANNELS-1:0] ext_irq_flag_reg_q;
  logic [CHANNELS-1:0] ext_irq_flag_reg_d;
  logic [CHANNELS-1:0] ext_irq_polarity_reg_q;
  logic [CHANNELS-1:0] pin_direction_reg_q;
  logic [CHANNELS-1:0] evt_status_q;
  logic [CHANNELS-1:0] evt_enable_q;
  logic [CHANNELS-1:0] pin_prev_q;
  logic [CHANNELS-1:0] edge_hit;
  logic [DATA_W-1:0] reg_rdata_q;
  logic irq_req_q;
  logic evt_irq_q;
  logic [CHANNELS-1:0] wr_flags;
  logic [CHANNELS-1:0] wr_clear;
  logic [CHANNELS-1:0] ext_irq_enable_reg_d;
  logic [CHANNELS-1:0] evt_enable_d;

  function automatic logic hit_at(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
    return a == ofs;
  endfunction : hit_at

  function automatic logic [DATA_W-1:0] widen(input logic [CHANNELS-1:0] v);
    logic [DATA_W-1:0] r;
    r = '0;
    r[CHANNELS-1:0] = v;
    return r;
  endfunction : widen

  assign wr_flags = (reg_wr && hit_at(reg_addr, OFS_FLAGS)) ? '1 : '0;
  assign wr_clear = (reg_wr && hit_at(reg_addr, OFS_EVT_CLEAR)) ?
                    reg_wdata[CHANNELS-1:0] : '0;
  assign ext_irq_enable_reg_d = (reg_wr && hit_at(reg_addr, OFS_ENABLE)) ?
                                reg_wdata[CHANNELS-1:0] : ext_irq_enable_reg_q;
  assign evt_enable_d = (reg_wr && hit_at(reg_addr, OFS_EVT_ENABLE)) ?
                        reg_wdata[CHANNELS-1:0] : evt_enable_q;

  // Pin history follows the pins even in reset, so a pin that idles high
  // gives no false edge when reset is released.
  always_ff @(posedge sys_clk) begin
    pin_prev_q <= ext_pin;
  end

  always_comb begin
    for (int i = 0; i < CHANNELS; i++) begin
      edge_hit[i] = !pin_direction_reg_q[i] &&
                    (ext_irq_polarity_reg_q[i] ? (pin_prev_q[i] && !ext_pin[i])
                                               : (!pin_prev_q[i] && ext_pin[i]));
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ext_irq_enable_reg_q <= RST_ENABLE[CHANNELS-1:0];
    end else if (reg_wr && hit_at(reg_addr, OFS_ENABLE)) begin
      ext_irq_enable_reg_q <= reg_wdata[CHANNELS-1:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ext_irq_polarity_reg_q <= RST_POLARITY[CHANNELS-1:0];
    end else if (reg_wr && hit_at(reg_addr, OFS_POLARITY)) begin
      ext_irq_polarity_reg_q <= reg_wdata[CHANNELS-1:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pin_direction_reg_q <= RST_DIRECTION[CHANNELS-1:0];
    end else if (reg_wr && hit_at(reg_addr, OFS_DIRECTION)) begin
      pin_direction_reg_q <= reg_wdata[CHANNELS-1:0];
    end
  end

  // sticky flags, software write, edge wins
  // An edge in the cycle of a clearing write still sets the flag, so no event is lost.
  always_comb begin
    ext_irq_flag_reg_d = (ext_irq_flag_reg_q & ~wr_flags) |
                         (reg_wdata[CHANNELS-1:0] & wr_flags) | edge_hit;
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ext_irq_flag_reg_q <= RST_FLAGS[CHANNELS-1:0];
    end else begin
      ext_irq_flag_reg_q <= ext_irq_flag_reg_d;
    end
  end

  // Event status, write-one clear, set wins.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      evt_status_q <= RST_EVT[CHANNELS-1:0];
    end else begin
      evt_status_q <= (evt_status_q & ~wr_clear) | edge_hit;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      evt_enable_q <= RST_EVT[CHANNELS-1:0];
    end else if (reg_wr && hit_at(reg_addr, OFS_EVT_ENABLE)) begin
      evt_enable_q <= reg_wdata[CHANNELS-1:0];
    end
  end

  // request from next flag state
  // Next flags and enables keep the output registered yet aligned with both.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      irq_req_q <= 1'b0;
    end else begin
      irq_req_q <= |(ext_irq_flag_reg_d & ext_irq_enable_reg_d);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      evt_irq_q <= 1'b0;
    end else begin
      evt_irq_q <= |(((evt_status_q & ~wr_clear) | edge_hit) & evt_enable_d);
    end
  end

  // Read data stands one cycle after the strobe and reads zero otherwise.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      reg_rdata_q <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        OFS_ENABLE: reg_rdata_q <= widen(ext_irq_enable_reg_q);
        OFS_FLAGS: reg_rdata_q <= widen(ext_irq_flag_reg_q);
        OFS_POLARITY: reg_rdata_q <= widen(ext_irq_polarity_reg_q);
        OFS_DIRECTION: reg_rdata_q <= widen(pin_direction_reg_q);
        OFS_EVT_STATUS: reg_rdata_q <= widen(evt_status_q);
        OFS_EVT_ENABLE: reg_rdata_q <= widen(evt_enable_q);
        default: reg_rdata_q <= UNMAPPED_READ;
      endcase
    end else begin
      reg_rdata_q <= '0;
    end
  end

  assign reg_rdata = reg_rdata_q;
  assign irq_req = irq_req_q;
  assign evt_irq = evt_irq_q;

  chk_edge_sets_flag: assert property (@(posedge sys_clk) disable iff (reset)
    |edge_hit |=> ((ext_irq_flag_reg_q & $past(edge_hit)) == $past(edge_hit)))
    else $error("Detected edge did not set its flag.");

  chk_flag_sticky: assert property (@(posedge sys_clk) disable iff (reset)
    (!(reg_wr && reg_addr == OFS_FLAGS)) |=>
      ((ext_irq_flag_reg_q & $past(ext_irq_flag_reg_q)) == $past(ext_irq_flag_reg_q)))
    else $error("Flag dropped without a software write.");

  chk_sw_set_irq: assert property (@(posedge sys_clk) disable iff (reset)
    (reg_wr && reg_addr == OFS_FLAGS &&
     |(reg_wdata[CHANNELS-1:0] & ext_irq_enable_reg_q)) |=> irq_req)
    else $error("Software set flag gave no request.");

  chk_irq_or: assert property (@(posedge sys_clk) disable iff (reset)
    ##1 (irq_req == |(ext_irq_flag_reg_q & ext_irq_enable_reg_q)))
    else $error("Request does not match enabled flags.");

  chk_disabled_quiet: assert property (@(posedge sys_clk) disable iff (reset)
    (ext_irq_enable_reg_q == '0) |-> !irq_req)
    else $error("Request with all channels disabled.");

  chk_rise_only: assert property (@(posedge sys_clk) disable iff (reset)
    (!ext_irq_polarity_reg_q[0] && pin_prev_q[0] && !ext_pin[0]) |-> !edge_hit[0])
    else $error("Falling edge hit on rising select.");

  chk_fall_hit: assert property (@(posedge sys_clk) disable iff (reset)
    (ext_irq_polarity_reg_q[1] && !pin_direction_reg_q[1] && $fell(ext_pin[1])
     && pin_prev_q[1]) |-> edge_hit[1])
    else $error("Falling edge missed on falling select.");

  chk_output_ignored: assert property (@(posedge sys_clk) disable iff (reset)
    (pin_direction_reg_q == '1) |-> (edge_hit == '0))
    else $error("Edge seen on output pin.");

  chk_sw_clear: assert property (@(posedge sys_clk) disable iff (reset)
    (reg_wr && reg_addr == OFS_FLAGS && reg_wdata == '0 && edge_hit == '0)
      |=> (ext_irq_flag_reg_q == '0))
    else $error("Software clear failed.");

  // Named steps that the multi-step checks below are built from.
  sequence flag_write_seq;
    reg_wr && (reg_addr == OFS_FLAGS);
  endsequence

  sequence enable_clear_seq;
    reg_wr && (reg_addr == OFS_ENABLE) && (reg_wdata == '0);
  endsequence

  sequence rise_ch0_seq;
    !ext_irq_polarity_reg_q[0] && !pin_direction_reg_q[0] && !pin_prev_q[0] && ext_pin[0];
  endsequence

  sequence rise_ch1_seq;
    ext_irq_polarity_reg_q[1] && !pin_prev_q[1] && ext_pin[1];
  endsequence

  sequence flags_read_seq;
    reg_rd && (reg_addr == OFS_FLAGS);
  endsequence

  chk_sw_write_flag: assert property (@(posedge sys_clk) disable iff (reset)
    (flag_write_seq ##0 (edge_hit == '0)) |=>
      (ext_irq_flag_reg_q == $past(reg_wdata[CHANNELS-1:0])))
    else $error("Software flag write did not land.");

  chk_disable_drops: assert property (@(posedge sys_clk) disable iff (reset)
    enable_clear_seq |=> !irq_req)
    else $error("Request stayed up after all channels were disabled.");

  chk_rise_hit: assert property (@(posedge sys_clk) disable iff (reset)
    rise_ch0_seq |-> edge_hit[0] ##1 ext_irq_flag_reg_q[0])
    else $error("Rising edge missed on rising select.");

  chk_fall_only: assert property (@(posedge sys_clk) disable iff (reset)
    rise_ch1_seq |-> !edge_hit[1])
    else $error("Rising edge hit on falling select.");

  chk_polarity_local: assert property (@(posedge sys_clk) disable iff (reset)
    (rise_ch0_seq ##0 ext_irq_polarity_reg_q[1]) |-> edge_hit[0])
    else $error("Neighbour polarity changed channel 0 detection.");

  chk_flags_read: assert property (@(posedge sys_clk) disable iff (reset)
    flags_read_seq |=> (reg_rdata[CHANNELS-1:0] == $past(ext_irq_flag_reg_q)))
    else $error("Flag read returned the wrong value.");

  chk_dir_gate: assert property (@(posedge sys_clk) disable iff (reset)
    (|(ext_pin ^ pin_prev_q)) |-> ((edge_hit & pin_direction_reg_q) == '0))
    else $error("Edge taken on a pin set as output.");

  chk_edge_sets_status: assert property (@(posedge sys_clk) disable iff (reset)
    |edge_hit |=> ((evt_status_q & $past(edge_hit)) == $past(edge_hit)))
    else $error("Detected edge did not set its status bit.");

  chk_irq_needs_flag: assert property (@(posedge sys_clk) disable iff (reset)
    (ext_irq_flag_reg_q == '0) |-> !irq_req)
    else $error("Request with no flag set.");

endmodule : port_ext_irq_edge_detect
`default_nettype wire
